// >>> verilog/acbd_consts.vh
// Constants of the command byte decoder
`ifndef ACBD_CONSTS_VH
`define ACBD_CONSTS_VH
// Clock
`define ACBD_CLK_PERIOD_NS 100
// Leading bit patterns of a command byte
`define ACBD_SEL_CONV_BIT 7
`define ACBD_SEL_SETUP 2'b01
`define ACBD_SEL_AVG 3'b001
`define ACBD_SEL_RESET 4'b0001
// Conversion byte fields
`define ACBD_CONV_CH_HI 6
`define ACBD_CONV_CH_LO 3
`define ACBD_CONV_SWEEP_HI 2
`define ACBD_CONV_SWEEP_LO 1
`define ACBD_CONV_TEMP 0
// Setup byte fields
`define ACBD_SETUP_CLK_HI 5
`define ACBD_SETUP_CLK_LO 4
`define ACBD_SETUP_REF_HI 3
`define ACBD_SETUP_REF_LO 2
`define ACBD_SETUP_PAIR_HI 1
`define ACBD_SETUP_PAIR_LO 0
// Averaging byte fields
`define ACBD_AVG_EN 4
`define ACBD_AVG_CNT_HI 3
`define ACBD_AVG_CNT_LO 2
`define ACBD_AVG_REP_HI 1
`define ACBD_AVG_REP_LO 0
// Reset byte field
`define ACBD_RST_FIFO_ONLY 3
// Field encodings
`define ACBD_SWEEP_LOW_TO_N 2'b00
`define ACBD_SWEEP_N_TO_TOP 2'b01
`define ACBD_SWEEP_REPEAT 2'b10
`define ACBD_SWEEP_SINGLE 2'b11
`define ACBD_CLK_EXT 2'b11
`define ACBD_REF_INT_AUTO_OFF 2'b00
`define ACBD_REF_EXT_DIFF 2'b11
`define ACBD_PAIR_UNIPOLAR 2'b10
`define ACBD_PAIR_BIPOLAR 2'b11
// Power-up values
`define ACBD_RST_BYTE 8'h00
`define ACBD_RST_CLK_MODE 2'b10
`define ACBD_RST_FIELD2 2'b00
// Samples per result and repeat counts per select code
`define ACBD_AVG_N0 6'h04
`define ACBD_AVG_N1 6'h08
`define ACBD_AVG_N2 6'h10
`define ACBD_AVG_N3 6'h20
`define ACBD_REP_N0 5'h04
`define ACBD_REP_N1 5'h08
`define ACBD_REP_N2 5'h0C
`define ACBD_REP_N3 5'h10
// Timing in ns
`define ACBD_T_CNV_NS 3500
`define ACBD_T_TS_NS 65000
`define ACBD_T_RP_NS 65000
`endif

// >>> verilog/acbd_serial_rx.v
// Serial byte receiver: pin synchronisers, clock edge finder, shifter
`timescale 1ns/10ps
`default_nettype none
module acbd_serial_rx (
   input wire clk,
   input wire reset_n,
   input wire sclk_pin,
   input wire cs_n_pin,
   input wire din_pin,
   output reg byte_valid,
   output reg [7:0] byte_data,
   output wire cs_active
);
   // ==========================================
   // Synchronisers
   reg [2:0] meta_q;
   reg [2:0] sync_q;
   reg sclk_prev_q;
   reg cs_prev_q;
   reg [2:0] bit_cnt_q;
   reg [6:0] shift_q;
   wire sclk_s = sync_q[2];
   wire cs_n_s = sync_q[1];
   wire din_s = sync_q[0];
   wire sclk_rise = sclk_s & ~sclk_prev_q;
   wire cs_fall = ~cs_n_s & cs_prev_q;
   assign cs_active = ~cs_n_s;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         // Idle pin levels, so no false clock edge follows reset
         meta_q <= 3'h3;
         sync_q <= 3'h3;
         sclk_prev_q <= 1'b0;
         cs_prev_q <= 1'b1;
      end else begin
         meta_q <= {sclk_pin, cs_n_pin, din_pin};
         sync_q <= meta_q;
         sclk_prev_q <= sclk_s;
         cs_prev_q <= cs_n_s;
      end
   end

   // ==========================================
   // Shifter
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bit_cnt_q <= 3'h0;
         shift_q <= 7'h00;
         byte_valid <= 1'b0;
         byte_data <= 8'h00;
      end else begin
         byte_valid <= 1'b0;
         if (cs_n_s | cs_fall) begin
            bit_cnt_q <= 3'h0;
         end else if (sclk_rise) begin
            shift_q <= {shift_q[5:0], din_s};
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h7) begin
               byte_valid <= 1'b1;
               byte_data <= {shift_q, din_s};
            end
         end
      end
   end
endmodule // acbd_serial_rx
`default_nettype wire

// >>> verilog/acbd_decoder.v
// Command byte decoder with pair registers, scan planner and scan timer
// How it works
// - Bytes arrive MSB first; leading 1, 01, 001, 0001 pick the target register.
// - Setup byte: bits 5:4 clock mode, 3:2 reference, 1:0 pair address.
// - Averaging byte: bit 4 enable, 3:2 sample count, 1:0 repeat count.
// - Conversion bits 6:3 give channel N in plain binary.
// - Sweep 00 converts channels 0 through N.
// - Sweep 01 converts N through the highest channel present.
// - Sweep 10 converts N repeatedly; repeat select sets result count.
// - Sweep 11 converts channel N exactly once.
// - Temperature bit adds one measurement as first result.
// - Sweeps 00/01 give one result per single channel or pair.
// - Clock modes 1x start on conversion byte; 0x on start pulse.
// - Channels taken as start input or negative reference are skipped.
// - Pair chosen by its lower channel; pair with taken member ignored.
// - Pair address 10/11 routes next byte to unipolar/bipolar register.
// - Pair address 00/01 leaves pair registers; next byte is command.
// - Pair set in both registers counts as unipolar.
// - Unipolar pairs give straight binary, bipolar two's complement.
// - Averaging enable averages up to 32 samples in every sweep.
// - External clock mode never averages.
// - Timed modes run sample time x samples x results plus extras.
// - Reset byte: bit set clears FIFO, clear restores all defaults.
// - Power-up all zero except clock mode 10.
// - Bits taken on rising serial clock; select fall starts new byte.
`timescale 1ns/10ps
`default_nettype none
`include "acbd_consts.vh"
module acbd_decoder #(
   parameter NUM_CHAN = 16,
   parameter T_CNV_NS = `ACBD_T_CNV_NS,
   parameter T_TS_NS = `ACBD_T_TS_NS,
   parameter T_RP_NS = `ACBD_T_RP_NS
) (
   input wire CLK,
   input wire RESET_N,
   input wire SCLK,
   input wire CS_N,
   input wire DIN,
   input wire CONVERT_START_N,
   output reg [3:0] CONV_CHANNEL,
   output reg [1:0] SWEEP_MODE,
   output reg TEMP_REQUEST,
   output reg [1:0] CLOCK_MODE,
   output reg [1:0] VREF_MODE,
   output reg [1:0] PAIR_REG_ADDR,
   output reg AVERAGING_ENABLE,
   output reg [1:0] AVG_COUNT_SEL,
   output reg [1:0] REPEAT_COUNT_SEL,
   output reg [7:0] UNIPOLAR_PAIR_BITS,
   output reg [7:0] BIPOLAR_PAIR_BITS,
   output reg [7:0] PAIR_TWOS_COMP,
   output reg SCAN_START,
   output reg [15:0] SCAN_CHAN_MASK,
   output reg [4:0] SCAN_RESULT_COUNT,
   output reg SCAN_TEMP_FIRST,
   output reg [5:0] SCAN_SAMPLES,
   output reg SCAN_BUSY,
   output reg FIFO_CLEAR
);
   // ==========================================
   // Timing counts
   // Rounded up so a scan never ends early
   localparam integer T_CNV_CYC = (T_CNV_NS + `ACBD_CLK_PERIOD_NS - 1) / `ACBD_CLK_PERIOD_NS;
   localparam integer T_TS_CYC = (T_TS_NS + `ACBD_CLK_PERIOD_NS - 1) / `ACBD_CLK_PERIOD_NS;
   localparam integer T_RP_CYC = (T_RP_NS + `ACBD_CLK_PERIOD_NS - 1) / `ACBD_CLK_PERIOD_NS;

   // Byte routing states
   localparam [1:0] ST_CMD = 2'b00;
   localparam [1:0] ST_UNI = 2'b01;
   localparam [1:0] ST_BI = 2'b10;

   // ==========================================
   // Serial receiver
   // Serial pin synchronisers live inside the receiver
   wire byte_valid;
   wire [7:0] byte_data;
   wire cs_active;

   acbd_serial_rx u_rx (
      .clk(CLK),
      .reset_n(RESET_N),
      .sclk_pin(SCLK),
      .cs_n_pin(CS_N),
      .din_pin(DIN),
      .byte_valid(byte_valid),
      .byte_data(byte_data),
      .cs_active(cs_active)
   );

   // ==========================================
   // Convert start pin
   // Reset to the idle high level so reset makes no false start
   reg cst_meta_q;
   reg cst_sync_q;
   reg cst_prev_q;
   wire cst_fall = ~cst_sync_q & cst_prev_q;

   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         cst_meta_q <= 1'b1;
         cst_sync_q <= 1'b1;
         cst_prev_q <= 1'b1;
      end else begin
         cst_meta_q <= CONVERT_START_N;
         cst_sync_q <= cst_meta_q;
         cst_prev_q <= cst_sync_q;
      end
   end

   // ==========================================
   // Byte classification
   wire is_conv = byte_data[`ACBD_SEL_CONV_BIT];
   wire is_setup = (byte_data[7:6] == `ACBD_SEL_SETUP);
   wire is_avg = (byte_data[7:5] == `ACBD_SEL_AVG);
   wire is_reset = (byte_data[7:4] == `ACBD_SEL_RESET);
   // Three lowest bits of a reset byte are never read
   wire [1:0] new_pair_addr = byte_data[`ACBD_SETUP_PAIR_HI:`ACBD_SETUP_PAIR_LO];

   reg [1:0] route_q;
   reg conv_written;

   // ==========================================
   // Register file
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         route_q <= ST_CMD;
         CONV_CHANNEL <= 4'h0;
         SWEEP_MODE <= 2'h0;
         TEMP_REQUEST <= 1'b0;
         CLOCK_MODE <= `ACBD_RST_CLK_MODE;
         VREF_MODE <= `ACBD_RST_FIELD2;
         PAIR_REG_ADDR <= `ACBD_RST_FIELD2;
         AVERAGING_ENABLE <= 1'b0;
         AVG_COUNT_SEL <= 2'h0;
         REPEAT_COUNT_SEL <= 2'h0;
         UNIPOLAR_PAIR_BITS <= `ACBD_RST_BYTE;
         BIPOLAR_PAIR_BITS <= `ACBD_RST_BYTE;
         FIFO_CLEAR <= 1'b0;
         conv_written <= 1'b0;
      end else begin
         FIFO_CLEAR <= 1'b0;
         conv_written <= 1'b0;
         if (!cs_active) begin
            route_q <= ST_CMD; // Pair data must follow in the same frame
         end else if (byte_valid) begin
            case (route_q)
               // Data byte of a pair write is never decoded as a command
               ST_UNI: begin
                  UNIPOLAR_PAIR_BITS <= byte_data;
                  route_q <= ST_CMD;
               end
               ST_BI: begin
                  BIPOLAR_PAIR_BITS <= byte_data;
                  route_q <= ST_CMD;
               end
               default: begin
                  if (is_conv) begin
                     CONV_CHANNEL <= byte_data[`ACBD_CONV_CH_HI:`ACBD_CONV_CH_LO];
                     SWEEP_MODE <= byte_data[`ACBD_CONV_SWEEP_HI:`ACBD_CONV_SWEEP_LO];
                     TEMP_REQUEST <= byte_data[`ACBD_CONV_TEMP];
                     conv_written <= 1'b1;
                  end else if (is_setup) begin
                     CLOCK_MODE <= byte_data[`ACBD_SETUP_CLK_HI:`ACBD_SETUP_CLK_LO];
                     VREF_MODE <= byte_data[`ACBD_SETUP_REF_HI:`ACBD_SETUP_REF_LO];
                     PAIR_REG_ADDR <= new_pair_addr;
                     if (new_pair_addr == `ACBD_PAIR_UNIPOLAR) begin
                        route_q <= ST_UNI;
                     end else if (new_pair_addr == `ACBD_PAIR_BIPOLAR) begin
                        route_q <= ST_BI;
                     end else begin
                        route_q <= ST_CMD;
                     end
                  end else if (is_avg) begin
                     AVERAGING_ENABLE <= byte_data[`ACBD_AVG_EN];
                     AVG_COUNT_SEL <= byte_data[`ACBD_AVG_CNT_HI:`ACBD_AVG_CNT_LO];
                     REPEAT_COUNT_SEL <= byte_data[`ACBD_AVG_REP_HI:`ACBD_AVG_REP_LO];
                  end else if (is_reset) begin
                     if (byte_data[`ACBD_RST_FIFO_ONLY]) begin
                        FIFO_CLEAR <= 1'b1;
                     end else begin
                        CONV_CHANNEL <= 4'h0;
                        SWEEP_MODE <= 2'h0;
                        TEMP_REQUEST <= 1'b0;
                        CLOCK_MODE <= `ACBD_RST_CLK_MODE;
                        VREF_MODE <= `ACBD_RST_FIELD2;
                        PAIR_REG_ADDR <= `ACBD_RST_FIELD2;
                        AVERAGING_ENABLE <= 1'b0;
                        AVG_COUNT_SEL <= 2'h0;
                        REPEAT_COUNT_SEL <= 2'h0;
                        UNIPOLAR_PAIR_BITS <= `ACBD_RST_BYTE;
                        BIPOLAR_PAIR_BITS <= `ACBD_RST_BYTE;
                        FIFO_CLEAR <= 1'b1;
                     end
                  end
               end
            endcase
         end
      end
   end

   // ==========================================
   // Pair output format
   // Unipolar wins where both bits are set
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         PAIR_TWOS_COMP <= 8'h00;
      end else begin
         PAIR_TWOS_COMP <= BIPOLAR_PAIR_BITS & ~UNIPOLAR_PAIR_BITS;
      end
   end

   // ==========================================
   // Scan planner
   // Start pin shares the top channel unless clock mode is 1x
   wire start_pin_taken = ~CLOCK_MODE[1];
   wire ref_neg_taken = (VREF_MODE == `ACBD_REF_EXT_DIFF);
   wire ext_clock = (CLOCK_MODE == `ACBD_CLK_EXT);
   wire [7:0] pair_diff = UNIPOLAR_PAIR_BITS | BIPOLAR_PAIR_BITS;

   reg [15:0] taken;
   reg [15:0] plan_mask;
   reg [4:0] plan_count;
   reg [4:0] rep_count;
   reg [5:0] plan_samples;
   reg in_rng;
   reg diff;
   reg single_ok;
   integer c;

   always @* begin
      c = 0;
      plan_samples = 6'h01;
      taken = 16'h0000;
      taken[NUM_CHAN-1] = start_pin_taken;
      taken[NUM_CHAN-2] = ref_neg_taken;
      plan_mask = 16'h0000;
      plan_count = 5'h00;
      in_rng = 1'b0;
      diff = 1'b0;
      // A pair converts on its lower channel, so its partner must be free too
      single_ok = !taken[CONV_CHANNEL];
      if (pair_diff[~CONV_CHANNEL[3:1]] && taken[{CONV_CHANNEL[3:1], 1'b1}]) begin
         single_ok = 1'b0;
      end
      case (REPEAT_COUNT_SEL)
         2'b00: rep_count = `ACBD_REP_N0;
         2'b01: rep_count = `ACBD_REP_N1;
         2'b10: rep_count = `ACBD_REP_N2;
         default: rep_count = `ACBD_REP_N3;
      endcase
      // Clock mode 11 never scans, so every sweep acts as single
      if ((SWEEP_MODE == `ACBD_SWEEP_LOW_TO_N || SWEEP_MODE == `ACBD_SWEEP_N_TO_TOP) && !ext_clock) begin
         for (c = 0; c < NUM_CHAN; c = c + 1) begin
            if (SWEEP_MODE == `ACBD_SWEEP_LOW_TO_N) begin
               in_rng = (c <= CONV_CHANNEL);
            end else begin
               in_rng = (c >= CONV_CHANNEL);
            end
            // Odd member of a pair rides on its even partner
            diff = pair_diff[7 - c/2];
            if (in_rng && diff && (c % 2 == 0)) begin
               if (!taken[c] && !taken[c+1]) begin
                  plan_mask[c] = 1'b1;
                  plan_count = plan_count + 5'h01;
               end
            end else if (in_rng && !diff && !taken[c]) begin
               plan_mask[c] = 1'b1;
               plan_count = plan_count + 5'h01;
            end
         end
      end else if (single_ok) begin
         plan_mask[CONV_CHANNEL] = 1'b1;
         if (SWEEP_MODE == `ACBD_SWEEP_REPEAT && !ext_clock) begin
            plan_count = rep_count;
         end else begin
            plan_count = 5'h01;
         end
      end
      if (AVERAGING_ENABLE && !ext_clock) begin
         case (AVG_COUNT_SEL)
            2'b00: plan_samples = `ACBD_AVG_N0;
            2'b01: plan_samples = `ACBD_AVG_N1;
            2'b10: plan_samples = `ACBD_AVG_N2;
            default: plan_samples = `ACBD_AVG_N3;
         endcase
      end else begin
         plan_samples = 6'h01;
      end
   end

   // ==========================================
   // Scan trigger
   // Mode 1x: conversion byte; mode 0x: start pin falling edge
   wire trigger = CLOCK_MODE[1] ? conv_written : cst_fall;
   wire timed = ~CLOCK_MODE[0];

   // ==========================================
   // Scan timer
   // Reference wake is charged on every scan in auto-off mode,
   // since the reference sleeps again after each scan.
   wire [31:0] base_cyc = T_CNV_CYC * plan_samples * (plan_count + TEMP_REQUEST);
   wire [31:0] ts_cyc = TEMP_REQUEST ? T_TS_CYC : 0;
   wire [31:0] rp_cyc = (VREF_MODE == `ACBD_REF_INT_AUTO_OFF) ? T_RP_CYC : 0;
   wire [31:0] total_cyc = base_cyc + ts_cyc + rp_cyc;
   reg [23:0] busy_cnt_q;

   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         SCAN_START <= 1'b0;
         SCAN_CHAN_MASK <= 16'h0000;
         SCAN_RESULT_COUNT <= 5'h00;
         SCAN_TEMP_FIRST <= 1'b0;
         SCAN_SAMPLES <= 6'h00;
         SCAN_BUSY <= 1'b0;
         busy_cnt_q <= 24'h000000;
      end else begin
         SCAN_START <= 1'b0;
         // A trigger during a timed scan is dropped, not queued
         if (trigger && !SCAN_BUSY) begin
            SCAN_START <= 1'b1;
            SCAN_CHAN_MASK <= plan_mask;
            SCAN_RESULT_COUNT <= plan_count + {4'h0, TEMP_REQUEST};
            SCAN_TEMP_FIRST <= TEMP_REQUEST;
            SCAN_SAMPLES <= plan_samples;
            if (timed && !ext_clock && (total_cyc != 32'h0)) begin
               SCAN_BUSY <= 1'b1;
               busy_cnt_q <= total_cyc[23:0] - 24'h000001;
            end
         end else if (SCAN_BUSY) begin
            if (busy_cnt_q == 24'h000000) begin
               SCAN_BUSY <= 1'b0;
            end else begin
               busy_cnt_q <= busy_cnt_q - 24'h000001;
            end
         end
      end
   end
endmodule // acbd_decoder
`default_nettype wire

// >>> dv/acbd_assertions.sv
// Port-level checker for the command byte decoder
`timescale 1ns/10ps
`default_nettype none
module acbd_assertions (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic [3:0] CONV_CHANNEL,
   input wire logic [1:0] SWEEP_MODE,
   input wire logic TEMP_REQUEST,
   input wire logic [1:0] CLOCK_MODE,
   input wire logic AVERAGING_ENABLE,
   input wire logic [1:0] AVG_COUNT_SEL,
   input wire logic [7:0] UNIPOLAR_PAIR_BITS,
   input wire logic [7:0] BIPOLAR_PAIR_BITS,
   input wire logic [7:0] PAIR_TWOS_COMP,
   input wire logic SCAN_START,
   input wire logic [15:0] SCAN_CHAN_MASK,
   input wire logic [4:0] SCAN_RESULT_COUNT,
   input wire logic SCAN_TEMP_FIRST,
   input wire logic [5:0] SCAN_SAMPLES,
   input wire logic SCAN_BUSY,
   input wire logic FIFO_CLEAR
);
   // ==========
   // Checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   a_power_up_values: assert property ($rose(RESET_N) |-> CLOCK_MODE == 2'h2 && PAIR_TWOS_COMP == 8'h00)
      else $error("power-up values wrong");
   a_start_pulse: assert property (SCAN_START |=> !SCAN_START)
      else $error("scan start longer than one cycle");
   a_clear_pulse: assert property (FIFO_CLEAR |=> !FIFO_CLEAR)
      else $error("fifo clear longer than one cycle");
   a_timed_busy: assert property (SCAN_START && !CLOCK_MODE[0] && SCAN_RESULT_COUNT != 5'h00 |-> ##[0:1] SCAN_BUSY)
      else $error("timed scan without busy");
   a_busy_timed_only: assert property ($rose(SCAN_BUSY) |-> !CLOCK_MODE[0])
      else $error("busy in an untimed clock mode");
   a_temp_first: assert property (SCAN_START |-> SCAN_TEMP_FIRST == TEMP_REQUEST)
      else $error("temperature slot mismatch");
   a_ext_no_avg: assert property (SCAN_START && CLOCK_MODE == 2'h3 |-> SCAN_SAMPLES == 6'h01)
      else $error("averaging in external clock mode");
   a_avg_samples: assert property (SCAN_START && CLOCK_MODE != 2'h3 |->
      SCAN_SAMPLES == (AVERAGING_ENABLE ? 6'h04 << AVG_COUNT_SEL : 6'h01)) else $error("samples per result wrong");
   a_single_result: assert property (SCAN_START && SWEEP_MODE == 2'h3 && SCAN_CHAN_MASK != 16'h0000 |->
      SCAN_CHAN_MASK == 16'h0001 << CONV_CHANNEL && SCAN_RESULT_COUNT == 5'h01 + TEMP_REQUEST)
      else $error("single conversion scan wrong");
   a_low_sweep_top: assert property (SCAN_START && SWEEP_MODE == 2'h0 && CLOCK_MODE != 2'h3 |->
      (SCAN_CHAN_MASK >> CONV_CHANNEL) <= 16'h0001) else $error("channel above N in low sweep");
   a_high_sweep_base: assert property (SCAN_START && SWEEP_MODE == 2'h1 && CLOCK_MODE != 2'h3 |->
      (SCAN_CHAN_MASK & ((16'h0001 << CONV_CHANNEL) - 16'h0001)) == 16'h0000) else $error("channel below N");
   a_twos_comp_map: assert property (1'b1 |=>
      PAIR_TWOS_COMP == ($past(BIPOLAR_PAIR_BITS) & ~$past(UNIPOLAR_PAIR_BITS))) else $error("pair format wrong");
endmodule // acbd_assertions
bind acbd_decoder acbd_assertions u_chk (.CLK, .RESET_N, .CONV_CHANNEL, .SWEEP_MODE, .TEMP_REQUEST, .CLOCK_MODE,
   .AVERAGING_ENABLE, .AVG_COUNT_SEL, .UNIPOLAR_PAIR_BITS, .BIPOLAR_PAIR_BITS, .PAIR_TWOS_COMP, .SCAN_START,
   .SCAN_CHAN_MASK, .SCAN_RESULT_COUNT, .SCAN_TEMP_FIRST, .SCAN_SAMPLES, .SCAN_BUSY, .FIFO_CLEAR);
`default_nettype wire

// >>> dv/acbd_host_model.sv
// Serial master model driving the decoder pins
`timescale 1ns/10ps
`default_nettype none
module acbd_host_model (
   input wire logic CLK,
   output var logic SCLK,
   output var logic CS_N,
   output var logic DIN,
   output var logic CONVERT_START_N
);
   // ==========
   // Idle levels, serial clock parked
   localparam int HALF = 4;
   initial begin
      SCLK = 1'b0;
      CS_N = 1'b1;
      DIN = 1'b1;
      CONVERT_START_N = 1'b1;
   end
   // ==========
   // Frames, MSB first from d[15]
   // A count under 8 leaves a partial byte on purpose
   task automatic frame(input logic [15:0] d, input int n);
      int i;
      @(posedge CLK);
      CS_N <= 1'b0;
      for (i = 0; i < n; i++) begin
         DIN <= d[15 - i];
         repeat (HALF) @(posedge CLK);
         SCLK <= 1'b1;
         repeat (HALF) @(posedge CLK);
         SCLK <= 1'b0;
      end
      repeat (HALF) @(posedge CLK);
      CS_N <= 1'b1;
      DIN <= ~DIN; // Released line must not keep the last bit
      repeat (HALF) @(posedge CLK);
   endtask
   task automatic pulse_start();
      @(posedge CLK);
      CONVERT_START_N <= 1'b0;
      repeat (HALF) @(posedge CLK);
      CONVERT_START_N <= 1'b1;
   endtask
endmodule // acbd_host_model
`default_nettype wire

// >>> dv/adc_command_byte_decoder_tb_top.sv
// Self-checking bench for the command byte decoder
`timescale 1ns/10ps
`default_nettype none
module adc_command_byte_decoder_tb_top;
   logic CLK;
   logic RESET_N = 1'b0;
   wire SCLK, CS_N, DIN, CONVERT_START_N, TEMP_REQUEST, AVERAGING_ENABLE, SCAN_START, SCAN_TEMP_FIRST;
   wire SCAN_BUSY, FIFO_CLEAR;
   wire [1:0] SWEEP_MODE, CLOCK_MODE, VREF_MODE, PAIR_REG_ADDR, AVG_COUNT_SEL, REPEAT_COUNT_SEL;
   wire [3:0] CONV_CHANNEL;
   wire [7:0] UNIPOLAR_PAIR_BITS, BIPOLAR_PAIR_BITS, PAIR_TWOS_COMP;
   wire [15:0] SCAN_CHAN_MASK;
   wire [4:0] SCAN_RESULT_COUNT;
   wire [5:0] SCAN_SAMPLES;
   int miscompares = 0;
   int checks = 0;
   int n_start = 0;
   int n_clear = 0;
   int busy_cyc = 0;
   int cyc = 0;
   // ==========
   // Design and host; short timer constants give 3 cycles each
   acbd_decoder #(.T_CNV_NS(300), .T_TS_NS(300), .T_RP_NS(300)) u_dut (.CLK, .RESET_N, .SCLK, .CS_N, .DIN,
      .CONVERT_START_N, .CONV_CHANNEL, .SWEEP_MODE, .TEMP_REQUEST, .CLOCK_MODE, .VREF_MODE, .PAIR_REG_ADDR,
      .AVERAGING_ENABLE, .AVG_COUNT_SEL, .REPEAT_COUNT_SEL, .UNIPOLAR_PAIR_BITS, .BIPOLAR_PAIR_BITS,
      .PAIR_TWOS_COMP, .SCAN_START, .SCAN_CHAN_MASK, .SCAN_RESULT_COUNT, .SCAN_TEMP_FIRST, .SCAN_SAMPLES,
      .SCAN_BUSY, .FIFO_CLEAR);
   acbd_host_model u_host (.CLK, .SCLK, .CS_N, .DIN, .CONVERT_START_N);
   initial begin
      CLK = 1'b0;
      forever #50 CLK = ~CLK;
   end
   // ==========
   // Pulse counters and watchdog
   always @(posedge CLK) begin
      if (SCAN_START === 1'b1) n_start <= n_start + 1;
      if (FIFO_CLEAR === 1'b1) n_clear <= n_clear + 1;
      if (SCAN_BUSY === 1'b1) busy_cyc <= busy_cyc + 1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %0h seen %0h", name, exp, got);
      end
   endtask
   // ==========
   // One conversion byte, optional start pulse, then the scan plan
   task automatic conv(input logic [7:0] b, input bit pls, input logic [15:0] m, input logic [4:0] c,
      input logic [5:0] sm, input int bz);
      int s;
      int i;
      s = n_start;
      busy_cyc = 0;
      u_host.frame({b, 8'h00}, 8);
      if (pls) begin
         repeat (100) @(posedge CLK);
         chk("early start", n_start, s);
         u_host.pulse_start();
      end
      for (i = 0; i < 100 && n_start == s; i++) @(posedge CLK);
      repeat (100) @(posedge CLK);
      chk("start seen", n_start, s + 1);
      chk("channel", CONV_CHANNEL, b[6:3]);
      chk("sweep", {SWEEP_MODE, SCAN_TEMP_FIRST}, b[2:0]);
      chk("mask", SCAN_CHAN_MASK, m);
      chk("results", SCAN_RESULT_COUNT, c);
      chk("samples", SCAN_SAMPLES, sm);
      chk("busy cycles", busy_cyc, bz);
   endtask
   initial begin
      int c0;
      repeat (5) @(posedge CLK);
      RESET_N <= 1'b1;
      repeat (10) @(posedge CLK);
      chk("clock mode", CLOCK_MODE, 2'h2);
      chk("pair regs", {UNIPOLAR_PAIR_BITS, BIPOLAR_PAIR_BITS}, 16'h0000);
      chk("fields", {CONV_CHANNEL, SWEEP_MODE, TEMP_REQUEST, VREF_MODE, PAIR_REG_ADDR, AVERAGING_ENABLE,
         AVG_COUNT_SEL, REPEAT_COUNT_SEL}, 16'h0000);
      conv(8'hA8, 1'b0, 16'h003F, 5'h06, 6'h01, 21);
      conv(8'hE3, 1'b0, 16'hF000, 5'h05, 6'h01, 21);
      conv(8'hBC, 1'b0, 16'h0080, 5'h04, 6'h01, 15);
      conv(8'h9F, 1'b0, 16'h0008, 5'h02, 6'h01, 12);
      u_host.frame(16'h4800, 8);
      chk("setup fields", {CLOCK_MODE, VREF_MODE, PAIR_REG_ADDR}, 6'h08);
      conv(8'hF8, 1'b1, 16'h7FFF, 5'h0F, 6'h01, 45);
      u_host.frame(16'h3400, 8);
      chk("avg fields", {AVERAGING_ENABLE, AVG_COUNT_SEL, REPEAT_COUNT_SEL}, 5'h14);
      u_host.frame(16'h6800, 8);
      conv(8'h96, 1'b0, 16'h0004, 5'h01, 6'h08, 24);
      u_host.frame(16'h7800, 8);
      conv(8'hA0, 1'b0, 16'h0010, 5'h01, 6'h01, 0);
      u_host.frame(16'h4800, 5);
      chk("partial byte", CLOCK_MODE, 2'h3);
      u_host.frame(16'h6AC0, 16);
      u_host.frame(16'h6BA0, 16);
      chk("pair write", {UNIPOLAR_PAIR_BITS, BIPOLAR_PAIR_BITS}, 16'hC0A0);
      chk("twos comp", PAIR_TWOS_COMP, 8'h20);
      u_host.frame(16'h68B0, 16);
      repeat (100) @(posedge CLK);
      chk("pairs kept", {UNIPOLAR_PAIR_BITS, BIPOLAR_PAIR_BITS}, 16'hC0A0);
      chk("next byte command", CONV_CHANNEL, 4'h6);
      c0 = n_clear;
      u_host.frame(16'h1F00, 8);
      repeat (20) @(posedge CLK);
      chk("fifo clear", n_clear, c0 + 1);
      chk("regs kept", UNIPOLAR_PAIR_BITS, 8'hC0);
      u_host.frame(16'h1500, 8);
      repeat (20) @(posedge CLK);
      chk("defaults back", {UNIPOLAR_PAIR_BITS, BIPOLAR_PAIR_BITS}, 16'h0000);
      chk("clock mode back", {CLOCK_MODE, VREF_MODE, AVERAGING_ENABLE}, 5'h10);
      u_host.frame(16'h6C00, 8);
      conv(8'hE2, 1'b0, 16'hB000, 5'h03, 6'h01, 9);
      u_host.frame(16'h5B01, 16);
      conv(8'hF6, 1'b1, 16'h0000, 5'h00, 6'h01, 0);
      end_of_test();
   end
endmodule // adc_command_byte_decoder_tb_top
`default_nettype wire
